// [core/hcf_top.sv]
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Management select 0 routes MDIO/MDC to internal PHY, 1 external.
// - Unselected side: internal lines low, or external MDIO released, MDC low.
// - Management select is independent of external port enable and MII mux.
// - External MDIO level is latched at reset into presence bit.
// - Presence bit is read-only information, affecting nothing else.
// - External port enable selects external MII port, not management or clocks.
// - Soft reset without PHY clocks is abandoned and sets timeout bit.
// - Soft reset clears registers and error flags, except exempt bits and self-clears.
// - Writes are ignored until one read follows reset.
// - TX size sets TX space; status 512 bytes, data gets rest.
// - RX space is 16384 minus TX; status one sixteenth; data rest.
// - TX data FIFO space holds command words and payload.
// - RX data FIFO full within 4 DWORDs of its length.
// - Interface layer buffers fixed: 2K transmit, 128 bytes receive.
// - Transmit interface buffer refills from TX data FIFO, two frames max.
// - Receive overrun drops frames, counting each lost frame once.
// - Interface buffer levels are hidden from reported FIFO levels.
module hcf_top
  import hcf_pkg::*;
#(
  parameter int SOFT_RESET_TIMEOUT_CYC = HCF_SOFT_RESET_TIMEOUT_CYC
)
(
  input wire logic sys_clk_i, // 40 MHz clock
  input wire logic rst_n_i, // hard reset, active low
  input wire logic [7:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic phy_clks_running_i, // internal PHY clocks alive
  input wire logic mgmt_mdc_i, // management clock from MAC
  input wire logic mgmt_mdio_out_i, // management data out
  input wire logic mgmt_mdio_oe_n_i, // management drive, active low
  output logic mgmt_mdio_in_o, // management data in
  output logic int_mdc_o, // internal PHY MDC
  output logic int_mdio_out_o, // internal PHY MDIO out
  output logic int_mdio_oe_n_o, // internal MDIO drive, active low
  input wire logic int_mdio_in_i, // internal PHY MDIO in
  output logic ext_mdc_o, // external MDC
  output logic ext_mdio_out_o, // external MDIO out
  output logic ext_mdio_oe_n_o, // external MDIO drive, active low
  input wire logic ext_mdio_in_i, // external MDIO pin level
  output logic ext_port_en_o, // external MII port selected
  output logic mac_soft_rst_o, // MAC and system reset pulse
  input wire logic tx_err_i, // TX error event
  input wire logic rx_err_i, // RX error event
  input wire logic tx_fifo_valid_i, // TX data FIFO has a word
  output logic tx_fifo_ready_o, // pull a word into TX buffer
  input wire logic tx_fifo_eof_i, // word ends a frame
  input wire logic mac_tx_take_i, // MAC consumed a word
  input wire logic mac_tx_eof_i, // consumed word ended frame
  input wire logic rx_sof_i, // MAC frame start
  input wire logic rx_wr_i, // MAC writes a word
  input wire logic [15:0] rx_fifo_used_i, // RX data FIFO bytes used
  output logic rx_fifo_full_o, // RX data FIFO full
  output logic [15:0] tx_data_size_o, // TX data FIFO bytes
  output logic [15:0] rx_data_size_o // RX data FIFO bytes
);
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic read_seen_r;
  logic mgmt_sel_r;
  logic ext_en_r;
  logic ext_det_r;
  logic det_done_r;
  logic soft_reset_timeout_r;
  logic [3:0] txsz_r;
  logic tx_err_r;
  logic rx_err_r;
  logic [31:0] drop_cnt_r;
  logic [31:0] rdata_r;
  logic ack_r;
  logic soft_reset_trigger_req;
  logic soft_clr;
  logic wr_ok;
  logic [15:0] tx_stat_sz;
  logic [15:0] rx_stat_sz;
  logic [15:0] rx_data_sz;
  logic [15:0] tx_data_sz;
  logic rx_drop;
  logic [7:0] rx_mil_lvl;
  logic [11:0] tx_mil_lvl_r;
  logic [1:0] tx_mil_frames_r;
  logic [15:0] soft_reset_trigger_cnt_r;
  hcf_soft_reset_trigger_type soft_reset_trigger_st_r;
  logic bus_req;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // One-cycle wait, answer on the second edge
  assign bus_req = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !ack_r;
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req && !ack_r;
  end
  assign wr_ok = avs_write_i && ack_r && read_seen_r;
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      read_seen_r <= 1'b0;
    else if (avs_read_i && ack_r)
      read_seen_r <= 1'b1;
  end
  assign soft_reset_trigger_req = wr_ok && avs_byteenable_i[0] &&
    hit(avs_address_i, HCF_HARDWARE_CONFIGURATION_OFS) && avs_writedata_i[HCF_BIT_SOFT_RESET_TRIGGER];

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_reset_trigger_st_r <= HCF_IDLE;
      soft_reset_trigger_cnt_r <= 16'h0000;
    end
    else
      case (soft_reset_trigger_st_r)
        HCF_IDLE:
        begin
          soft_reset_trigger_cnt_r <= 16'h0000;
          if (soft_reset_trigger_req)
            soft_reset_trigger_st_r <= HCF_WAIT_CLK;
        end
        HCF_WAIT_CLK:
        begin
          soft_reset_trigger_cnt_r <= soft_reset_trigger_cnt_r + 16'h0001;
          if (phy_clks_running_i)
          begin
            soft_reset_trigger_st_r <= HCF_HOLD;
            soft_reset_trigger_cnt_r <= 16'h0000;
          end
          else if (32'(soft_reset_trigger_cnt_r) >= SOFT_RESET_TIMEOUT_CYC - 1)
            soft_reset_trigger_st_r <= HCF_IDLE;
        end
        HCF_HOLD:
        begin
          soft_reset_trigger_cnt_r <= soft_reset_trigger_cnt_r + 16'h0001;
          if (32'(soft_reset_trigger_cnt_r) >= HCF_SOFT_RESET_TRIGGER_HOLD_CYC - 1)
            soft_reset_trigger_st_r <= HCF_IDLE;
        end
        default:
          soft_reset_trigger_st_r <= HCF_IDLE;
      endcase
  end
  assign soft_clr = (soft_reset_trigger_st_r == HCF_HOLD);
  assign mac_soft_rst_o = soft_clr;

  // timeout flag, cleared by next attempt
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      soft_reset_timeout_r <= 1'b0;
    else if (soft_reset_trigger_st_r == HCF_WAIT_CLK && !phy_clks_running_i &&
             32'(soft_reset_trigger_cnt_r) >= SOFT_RESET_TIMEOUT_CYC - 1)
      soft_reset_timeout_r <= 1'b1;
    else if (soft_reset_trigger_req)
      soft_reset_timeout_r <= 1'b0;
  end

  // Config bits; soft reset restores defaults
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mgmt_sel_r <= 1'b0;
      ext_en_r <= 1'b0;
      txsz_r <= HCF_TXSZ_RST;
    end
    else if (soft_clr)
    begin
      mgmt_sel_r <= 1'b0;
      ext_en_r <= 1'b0;
      txsz_r <= HCF_TXSZ_RST;
    end
    else if (wr_ok && hit(avs_address_i, HCF_HARDWARE_CONFIGURATION_OFS))
    begin
      if (avs_byteenable_i[0])
      begin
        mgmt_sel_r <= avs_writedata_i[HCF_BIT_MGMT_SEL];
        ext_en_r <= avs_writedata_i[HCF_BIT_EXT_EN];
      end
      if (avs_byteenable_i[2])
        txsz_r <= avs_writedata_i[HCF_TXSZ_LSB +: HCF_TXSZ_W];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_det_r <= 1'b0;
      det_done_r <= 1'b0;
    end
    else if (!det_done_r)
    begin
      ext_det_r <= ext_mdio_in_i;
      det_done_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_err_r <= 1'b0;
      rx_err_r <= 1'b0;
    end
    else
    begin
      tx_err_r <= tx_err_i || (tx_err_r && !soft_clr);
      rx_err_r <= rx_err_i || (rx_err_r && !soft_clr);
    end
  end

  assign mgmt_mdio_in_o = mgmt_sel_r ? ext_mdio_in_i : int_mdio_in_i;
  assign int_mdc_o = mgmt_sel_r ? 1'b0 : mgmt_mdc_i;
  assign int_mdio_out_o = mgmt_sel_r ? 1'b0 : mgmt_mdio_out_i;
  assign int_mdio_oe_n_o = mgmt_sel_r ? 1'b0 : mgmt_mdio_oe_n_i;
  assign ext_mdc_o = mgmt_sel_r ? mgmt_mdc_i : 1'b0;
  assign ext_mdio_out_o = mgmt_sel_r ? mgmt_mdio_out_i : 1'b0;
  assign ext_mdio_oe_n_o = mgmt_sel_r ? mgmt_mdio_oe_n_i : 1'b1;
  assign ext_port_en_o = ext_en_r;

  hcf_alloc u_alloc (
    .tx_size_i(txsz_r),
    .tx_data_o(tx_data_sz),
    .tx_stat_o(tx_stat_sz),
    .rx_data_o(rx_data_sz),
    .rx_stat_o(rx_stat_sz)
  );
  assign tx_data_size_o = tx_data_sz;
  assign rx_data_size_o = rx_data_sz;
  assign rx_fifo_full_o =
    (32'(rx_fifo_used_i) + HCF_FULL_MARGIN) >= 32'(rx_data_sz);

  // TX buffer pulls while room and under two frames
  assign tx_fifo_ready_o =
    (32'(tx_mil_lvl_r) + 4 <= HCF_MIL_TX_BYTES) &&
    (32'(tx_mil_frames_r) < HCF_MIL_TX_FRAMES) && !soft_clr;
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_mil_lvl_r <= 12'h000;
      tx_mil_frames_r <= 2'b00;
    end
    else if (soft_clr)
    begin
      tx_mil_lvl_r <= 12'h000;
      tx_mil_frames_r <= 2'b00;
    end
    else
    begin
      tx_mil_lvl_r <= tx_mil_lvl_r
        + (tx_fifo_valid_i && tx_fifo_ready_o ? 12'h004 : 12'h000)
        - (mac_tx_take_i && tx_mil_lvl_r != 12'h000 ? 12'h004 : 12'h000);
      tx_mil_frames_r <= tx_mil_frames_r
        + (tx_fifo_valid_i && tx_fifo_ready_o && tx_fifo_eof_i ? 2'b01 : 2'b00)
        - (mac_tx_take_i && mac_tx_eof_i && tx_mil_frames_r != 2'b00
           ? 2'b01 : 2'b00);
    end
  end

  hcf_rx_mil u_rx_mil (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clr_i(soft_clr),
    .sof_i(rx_sof_i),
    .wr_i(rx_wr_i),
    .drain_i(!rx_fifo_full_o),
    .level_o(rx_mil_lvl),
    .drop_o(rx_drop)
  );
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      drop_cnt_r <= 32'h0000_0000;
    else if (rx_drop)
      drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
    else if (soft_clr)
      drop_cnt_r <= 32'h0000_0000;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (avs_read_i && !ack_r)
    begin
      rdata_r <= 32'h0000_0000;
      if (hit(avs_address_i, HCF_HARDWARE_CONFIGURATION_OFS))
      begin
        rdata_r[HCF_BIT_MGMT_SEL] <= mgmt_sel_r;
        rdata_r[HCF_BIT_EXT_DET] <= ext_det_r;
        rdata_r[HCF_BIT_EXT_EN] <= ext_en_r;
        rdata_r[HCF_BIT_SOFT_RESET_TIMEOUT] <= soft_reset_timeout_r;
        rdata_r[HCF_BIT_SOFT_RESET_TRIGGER] <= (soft_reset_trigger_st_r != HCF_IDLE);
        rdata_r[HCF_TXSZ_LSB +: HCF_TXSZ_W] <= txsz_r;
      end
      else if (hit(avs_address_i, HCF_TX_INFO_OFS))
        rdata_r <= {tx_stat_sz, tx_data_sz};
      else if (hit(avs_address_i, HCF_RX_INFO_OFS))
        rdata_r <= {rx_stat_sz, rx_data_sz};
      else if (hit(avs_address_i, HCF_DROP_CNT_OFS))
        rdata_r <= drop_cnt_r;
      else if (hit(avs_address_i, HCF_ERR_OFS))
        rdata_r <= {30'h0000_0000, rx_err_r, tx_err_r};
    end
  end
  assign avs_readdata_o = rdata_r;
endmodule
`default_nettype wire

// [core/hcf_pkg.sv]
`default_nettype none
package hcf_pkg;
  localparam logic [7:0] HCF_HARDWARE_CONFIGURATION_OFS = 8'h00;
  localparam logic [7:0] HCF_TX_INFO_OFS = 8'h04;
  localparam logic [7:0] HCF_RX_INFO_OFS = 8'h08;
  localparam logic [7:0] HCF_MIL_CTRL_OFS = 8'h0c;
  localparam logic [7:0] HCF_DROP_CNT_OFS = 8'h10;
  localparam logic [7:0] HCF_ERR_OFS = 8'h14;
  localparam int HCF_BIT_SOFT_RESET_TRIGGER = 0;
  localparam int HCF_BIT_SOFT_RESET_TIMEOUT = 1;
  localparam int HCF_BIT_EXT_EN = 2;
  localparam int HCF_BIT_EXT_DET = 3;
  localparam int HCF_BIT_MGMT_SEL = 4;
  localparam int HCF_TXSZ_LSB = 16;
  localparam int HCF_TXSZ_W = 4;
  localparam logic [3:0] HCF_TXSZ_RST = 4'h5;
  localparam int unsigned HCF_TOTAL_BYTES = 16384;
  localparam int unsigned HCF_TXS_BYTES = 512;
  localparam int unsigned HCF_KB_BYTES = 1024;
  localparam int unsigned HCF_RXS_DIV = 16;
  localparam int unsigned HCF_FULL_MARGIN = 16;
  localparam int unsigned HCF_MIL_TX_BYTES = 2048;
  localparam int unsigned HCF_MIL_RX_BYTES = 128;
  localparam int unsigned HCF_MIL_TX_FRAMES = 2;
  localparam int HCF_SOFT_RESET_TIMEOUT_NS = 10000;
  localparam int HCF_CLK_NS = 25;
  localparam int HCF_SOFT_RESET_TIMEOUT_CYC = HCF_SOFT_RESET_TIMEOUT_NS / HCF_CLK_NS;
  localparam int HCF_SOFT_RESET_TRIGGER_HOLD_CYC = 4;
  typedef enum logic [1:0] {HCF_IDLE, HCF_WAIT_CLK, HCF_HOLD} hcf_soft_reset_trigger_type;
endpackage
`default_nettype wire

// [core/hcf_alloc.sv]
`timescale 1ns/10ps
`default_nettype none
module hcf_alloc
  import hcf_pkg::*;
(
  input wire logic [3:0] tx_size_i, // TX allocation in KB
  output logic [15:0] tx_data_o, // TX data FIFO bytes
  output logic [15:0] tx_stat_o, // TX status FIFO bytes
  output logic [15:0] rx_data_o, // RX data FIFO bytes
  output logic [15:0] rx_stat_o // RX status FIFO bytes
);
  logic [15:0] tx_total;
  logic [15:0] rx_total;
  // TX unit is one kilobyte
  assign tx_total = 16'(32'(tx_size_i) * HCF_KB_BYTES);
  // TX status fixed
  assign tx_stat_o = 16'(HCF_TXS_BYTES);
  assign tx_data_o = tx_total - 16'(HCF_TXS_BYTES);
  // RX remainder split
  assign rx_total = 16'(HCF_TOTAL_BYTES) - tx_total;
  assign rx_stat_o = 16'(32'(rx_total) / HCF_RXS_DIV);
  assign rx_data_o = rx_total - rx_stat_o;
endmodule
`default_nettype wire

// [core/hcf_rx_mil.sv]
`timescale 1ns/10ps
`default_nettype none
module hcf_rx_mil
  import hcf_pkg::*;
#(
  parameter int MIL_BYTES = HCF_MIL_RX_BYTES
)
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic clr_i, // soft reset clear
  input wire logic sof_i, // MAC frame start
  input wire logic wr_i, // MAC writes 4 bytes
  input wire logic drain_i, // move 4 bytes out
  output logic [7:0] level_o, // bytes held
  output logic drop_o // frame lost pulse
);
  logic [7:0] level_r;
  logic drop_frame_r;
  logic drop_r;
  logic full;
  assign full = (32'(level_r) + 4) > MIL_BYTES;
  assign level_o = level_r;
  assign drop_o = drop_r;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      level_r <= 8'h00;
    else if (clr_i)
      level_r <= 8'h00;
    else
      level_r <= level_r + ((wr_i && !full && !drop_frame_r && !sof_i) ||
        (wr_i && sof_i && !full) ? 8'h04 : 8'h00)
        - (drain_i && level_r != 8'h00 ? 8'h04 : 8'h00);
  end
  // Overrun drops frame
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drop_frame_r <= 1'b0;
      drop_r <= 1'b0;
    end
    else
    begin
      drop_r <= 1'b0;
      if (clr_i)
        drop_frame_r <= 1'b0;
      else if (wr_i && full && (sof_i || !drop_frame_r))
      begin
        drop_frame_r <= 1'b1;
        drop_r <= 1'b1;
      end
      else if (sof_i)
        drop_frame_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verif/hcf_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module hcf_top_asserts
  import hcf_pkg::*;
#(
  parameter int SOFT_RESET_TIMEOUT_CYC = HCF_SOFT_RESET_TIMEOUT_CYC
)
(
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic avs_waitrequest_o, // stall
  input wire logic mgmt_mdc_i, // mgmt clock
  input wire logic int_mdc_o, // internal clock
  input wire logic int_mdio_out_o, // internal data
  input wire logic ext_mdc_o, // external clock
  input wire logic ext_mdio_oe_n_o, // external drive
  input wire logic ext_port_en_o, // port select
  input wire logic mac_soft_rst_o, // soft reset
  input wire logic [15:0] rx_fifo_used_i, // RX used
  input wire logic rx_fifo_full_o, // RX full
  input wire logic [15:0] tx_data_size_o, // TX data
  input wire logic [15:0] rx_data_size_o // RX data
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_MDC_ROUTE: assert property
    (mgmt_mdc_i |-> int_mdc_o ^ ext_mdc_o)
    else $error("management clock not on exactly one side");
  AST_EXT_REL: assert property
    (int_mdc_o |-> ext_mdio_oe_n_o && !ext_mdc_o)
    else $error("external side active while internal selected");
  AST_INT_LOW: assert property
    (ext_mdc_o |-> !int_mdc_o && !int_mdio_out_o)
    else $error("internal lines not low while external selected");
  AST_SOFT_PULSE: assert property
    ($rose(mac_soft_rst_o) |-> mac_soft_rst_o[*4] ##1 !mac_soft_rst_o)
    else $error("soft reset pulse length wrong");
  AST_WAIT_ONE: assert property
    ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request stalled longer than one cycle");
  AST_WAIT_FIRST: assert property
    ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read answered without a wait cycle");
  AST_EXT_HOLD: assert property
    (!$past(avs_write_i) && !mac_soft_rst_o && !$past(mac_soft_rst_o)
    |-> $stable(ext_port_en_o))
    else $error("port enable changed without a write");
  AST_FULL: assert property
    (rx_fifo_full_o ==
    (int'(rx_fifo_used_i) + HCF_FULL_MARGIN >= int'(rx_data_size_o)))
    else $error("full flag disagrees with level");
  AST_SPLIT: assert property
    (int'(tx_data_size_o) + HCF_TXS_BYTES +
    int'(rx_data_size_o) * HCF_RXS_DIV / (HCF_RXS_DIV - 1)
    == HCF_TOTAL_BYTES)
    else $error("partition does not fill the memory");
  AST_TX_KB: assert property
    ((int'(tx_data_size_o) + HCF_TXS_BYTES) % HCF_KB_BYTES == 0)
    else $error("TX allocation not whole kilobytes");
  COV_SOFT_RESET_TRIGGER: cover property ($rose(mac_soft_rst_o));
  COV_WR_DONE: cover property (avs_write_i && !avs_waitrequest_o);
  COV_EXT: cover property (ext_mdc_o);
  COV_FULL: cover property ($rose(rx_fifo_full_o));
endmodule
bind hcf_top hcf_top_asserts #(.SOFT_RESET_TIMEOUT_CYC(SOFT_RESET_TIMEOUT_CYC)) hcf_top_asserts_i (
  .sys_clk_i, .rst_n_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
  .mgmt_mdc_i, .int_mdc_o, .int_mdio_out_o, .ext_mdc_o, .ext_mdio_oe_n_o,
  .ext_port_en_o, .mac_soft_rst_o, .rx_fifo_used_i, .rx_fifo_full_o,
  .tx_data_size_o, .rx_data_size_o);
`default_nettype wire

// [verif/hcf_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hcf_host_model
(
  input wire logic clk_i, // clock
  input wire logic waitrequest_i, // slave stall
  input wire logic [31:0] readdata_i, // read data
  output logic [7:0] address_o = 8'h00, // address
  output logic read_o = 1'b0, // read
  output logic write_o = 1'b0, // write
  output logic [31:0] writedata_o = 32'h0000_0000, // write data
  output logic [3:0] byteenable_o = 4'hf // lanes
);
  // Waitrequest and read data are taken at the rising edge itself, so the
  // values seen are those that stood just before the edge
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    logic busy;
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= d;
    read_o <= !w;
    write_o <= w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      busy = waitrequest_i;
      q = readdata_i;
      n++;
    end
    while (busy && n < 20);
    read_o <= 1'b0;
    write_o <= 1'b0;
    if (busy)
    begin
      tb_hcf_top.num_errors++;
      tb_hcf_top.end_of_test();
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb_hcf_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_hcf_top;
  import hcf_pkg::*;
  localparam int TO = 20;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, phy_clks_running_i = 1'b1;
  logic mgmt_mdc_i = 1'b1, mgmt_mdio_out_i = 1'b1, mgmt_mdio_oe_n_i = 1'b1;
  logic int_mdio_in_i = 1'b0, ext_mdio_in_i = 1'b1, tx_fifo_valid_i = 1'b0;
  logic tx_fifo_eof_i = 1'b0, mac_tx_take_i = 1'b0, mac_tx_eof_i = 1'b0;
  logic tx_err_i = 1'b0, rx_err_i = 1'b0, rx_sof_i = 1'b0, rx_wr_i = 1'b0;
  logic [15:0] rx_fifo_used_i = 16'h0000;
  logic [7:0] avs_address_i;
  logic avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  logic [3:0] avs_byteenable_i;
  logic mgmt_mdio_in_o, int_mdc_o, int_mdio_out_o, int_mdio_oe_n_o;
  logic ext_mdc_o, ext_mdio_out_o, ext_mdio_oe_n_o, ext_port_en_o;
  logic mac_soft_rst_o, tx_fifo_ready_o, rx_fifo_full_o;
  logic [15:0] tx_data_size_o, rx_data_size_o;
  int num_errors = 0, check_count = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  hcf_top #(.SOFT_RESET_TIMEOUT_CYC(TO)) hcf_top_i (.sys_clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .phy_clks_running_i, .mgmt_mdc_i, .mgmt_mdio_out_i, .mgmt_mdio_oe_n_i,
    .mgmt_mdio_in_o, .int_mdc_o, .int_mdio_out_o, .int_mdio_oe_n_o,
    .int_mdio_in_i, .ext_mdc_o, .ext_mdio_out_o, .ext_mdio_oe_n_o,
    .ext_mdio_in_i, .ext_port_en_o, .mac_soft_rst_o, .tx_err_i, .rx_err_i,
    .tx_fifo_valid_i, .tx_fifo_ready_o, .tx_fifo_eof_i,
    .mac_tx_take_i, .mac_tx_eof_i, .rx_sof_i, .rx_wr_i,
    .rx_fifo_used_i, .rx_fifo_full_o, .tx_data_size_o, .rx_data_size_o);
  hcf_host_model hcf_host_model_i (.clk_i(sys_clk_i),
    .waitrequest_i(avs_waitrequest_o), .readdata_i(avs_readdata_o),
    .address_o(avs_address_i), .read_o(avs_read_i),
    .write_o(avs_write_i), .writedata_o(avs_writedata_i),
    .byteenable_o(avs_byteenable_i));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    hcf_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    hcf_host_model_i.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_first;
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0014);
    rd(HCF_HARDWARE_CONFIGURATION_OFS, r);
    chk("cfg_reset", 32'h0005_0008, r);
    rd(8'h20, r);
    chk("unmapped", 32'h0000_0000, r);
  endtask
  task automatic t_route;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk_i);
      mgmt_mdio_oe_n_i <= (i == 0);
      wr(HCF_HARDWARE_CONFIGURATION_OFS, (i == 1) ? 32'h0005_0010 : 32'h0005_0004);
      @(negedge sys_clk_i);
      chk("int_mdc", 32'(i == 0), 32'(int_mdc_o));
      chk("int_mdio", 32'(i == 0), 32'(int_mdio_out_o));
      chk("ext_mdc", 32'(i == 1), 32'(ext_mdc_o));
      chk("ext_oe_n", 32'(i == 0), 32'(ext_mdio_oe_n_o));
      chk("mdio_in", 32'(i == 1), 32'(mgmt_mdio_in_o));
      chk("port_en", 32'(i == 0), 32'(ext_port_en_o));
      chk("int_oe_n", 32'(i == 0), 32'(int_mdio_oe_n_o));
      chk("ext_mdio", 32'(i == 1), 32'(ext_mdio_out_o));
    end
  endtask
  task automatic t_alloc;
    int tx;
    for (int k = 2; k < 15; k++)
    begin
      tx = k * 1024;
      wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'(k) << 16);
      @(negedge sys_clk_i);
      chk("tx_data", 32'(tx - 512), 32'(tx_data_size_o));
      chk("rx_data", 32'((16384 - tx) * 15 / 16), 32'(rx_data_size_o));
      rd(HCF_TX_INFO_OFS, r);
      chk("tx_info", {16'd512, 16'(tx - 512)}, r);
      rd(HCF_RX_INFO_OFS, r);
      chk("rx_info", {16'((16384 - tx) / 16),
        16'((16384 - tx) * 15 / 16)}, r);
    end
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0000);
  endtask
  task automatic t_full;
    @(posedge sys_clk_i);
    rx_fifo_used_i <= 16'd10544;
    @(negedge sys_clk_i);
    chk("full_edge", 32'h1, 32'(rx_fifo_full_o));
    @(posedge sys_clk_i);
    rx_fifo_used_i <= 16'd10540;
    @(negedge sys_clk_i);
    chk("full_below", 32'h0, 32'(rx_fifo_full_o));
  endtask
  task automatic t_drop;
    @(posedge sys_clk_i);
    rx_fifo_used_i <= 16'd10560;
    // Buffer holds 32 words, so 40 per frame overruns it each time
    repeat (2)
    begin
      @(posedge sys_clk_i);
      rx_sof_i <= 1'b1;
      repeat (40)
      begin
        @(posedge sys_clk_i);
        rx_sof_i <= 1'b0;
        rx_wr_i <= 1'b1;
      end
      @(posedge sys_clk_i);
      rx_wr_i <= 1'b0;
    end
    rd(HCF_DROP_CNT_OFS, r);
    chk("drops", 32'h0000_0002, r);
    rx_fifo_used_i <= 16'h0000;
  endtask
  task automatic t_soft_reset_trigger;
    int n;
    @(posedge sys_clk_i);
    tx_err_i <= 1'b1;
    rx_err_i <= 1'b1;
    @(posedge sys_clk_i);
    tx_err_i <= 1'b0;
    rx_err_i <= 1'b0;
    rd(HCF_ERR_OFS, r);
    chk("err_flags", 32'h0000_0003, r);
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0004);
    phy_clks_running_i <= 1'b0;
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0005);
    repeat (TO + 5) @(posedge sys_clk_i);
    rd(HCF_HARDWARE_CONFIGURATION_OFS, r);
    chk("cfg_timeout", 32'h0005_000e, r);
    phy_clks_running_i <= 1'b1;
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0005);
    for (n = 0; n < 50 && mac_soft_rst_o !== 1'b1; n++) @(negedge sys_clk_i);
    chk("soft_rst", 32'h1, 32'(mac_soft_rst_o));
    if (mac_soft_rst_o !== 1'b1) end_of_test;
    repeat (10) @(posedge sys_clk_i);
    rd(HCF_HARDWARE_CONFIGURATION_OFS, r);
    chk("cfg_after", 32'h0005_0008, r);
    rd(HCF_ERR_OFS, r);
    chk("err_after", 32'h0000_0000, r);
    rd(HCF_DROP_CNT_OFS, r);
    chk("drop_after", 32'h0000_0000, r);
  endtask
  task automatic t_txbuf;
    @(posedge sys_clk_i);
    tx_fifo_valid_i <= 1'b1;
    tx_fifo_eof_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("tx_ready", 32'h1, 32'(tx_fifo_ready_o));
    // Two single-word frames reach the frame limit
    repeat (2) @(posedge sys_clk_i);
    tx_fifo_valid_i <= 1'b0;
    tx_fifo_eof_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("tx_two_frames", 32'h0, 32'(tx_fifo_ready_o));
    @(posedge sys_clk_i);
    mac_tx_take_i <= 1'b1;
    mac_tx_eof_i <= 1'b1;
    @(posedge sys_clk_i);
    mac_tx_take_i <= 1'b0;
    mac_tx_eof_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("tx_refill", 32'h1, 32'(tx_fifo_ready_o));
  endtask
  task automatic t_hard;
    // Hard reset in mid-run relatches the strap, now pulled low
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    ext_mdio_in_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    wr(HCF_HARDWARE_CONFIGURATION_OFS, 32'h0005_0014);
    rd(HCF_HARDWARE_CONFIGURATION_OFS, r);
    chk("cfg_hard", 32'h0005_0000, r);
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_first();
    t_route();
    t_alloc();
    t_full();
    t_drop();
    t_soft_reset_trigger();
    t_txbuf();
    t_hard();
    end_of_test();
  end
endmodule
`default_nettype wire
